// ---- include/ppce_cfg.svh ----
/*
 * constants for the parallel engine condition unit and extended alu:
 * opcode field positions, extension register layout, codes.
 * assumes inclusion by bare name from the design files.
 */
`ifndef PPCE_CFG_SVH
`define PPCE_CFG_SVH
`define PPCE_COND_HI      35
`define PPCE_COND_LO      32
`define PPCE_FC_HI        26
`define PPCE_FC_LO        19
`define PPCE_X_ARITH      27
`define PPCE_X_ADD1       28
`define PPCE_X_ADDCIN     29
`define PPCE_X_SIGNEN     30
`define PPCE_X_SIGNSRC    31
`define PPCE_X_SIGNFC_HI  7
`define PPCE_X_SIGNFC_LO  0
`define PPCE_REL_ABS      2'h0
`define PPCE_REL_DRAM     2'h2
`define PPCE_REL_PRAM     2'h3
`define PPCE_EXT_RST      32'h0
`define PPCE_FLAGS_RST    4'h0
`endif

// ---- include/ppce_pkg.sv ----
/*
 * types shared by the condition unit and its alu.
 * assumes ppce_cfg.svh is on the include path.
 */
package ppce_pkg;
    typedef logic [31:0] ppce_word_t;
    typedef logic [7:0]  ppce_fcode_t;
    typedef enum logic [1:0] {
        PPCE_REL_ABS_M, PPCE_REL_RSV_M, PPCE_REL_DRAM_M, PPCE_REL_PRAM_M
    } ppce_rel_e;
endpackage

// ---- include/ppce_alu_if.sv ----
/*
 * interface joining the top block and its three-input alu.
 * assumes a single clock domain; purely combinational carrier.
 */
`timescale 1ns/1ps
`default_nettype none
interface ppce_alu_if;
    import ppce_pkg::*;
    ppce_word_t  a;
    ppce_word_t  b;
    ppce_word_t  c;
    ppce_fcode_t fcode;
    logic        arith;
    logic        add1;
    logic        addcin;
    logic        cin;
    ppce_word_t  res;
    logic        cout;
    modport top (output a, b, c, fcode, arith, add1, addcin, cin,
                 input res, cout);
    modport alu (input a, b, c, fcode, arith, add1, addcin, cin,
                 output res, cout);
endinterface
`default_nettype wire

// ---- verilog/ppce_alu.sv ----
/*
 * three-input extended alu: minterm boolean or A&f1+f2 arithmetic.
 * assumes operands and code are settled within the cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module ppce_alu (
    ppce_alu_if.alu p
);
    import ppce_pkg::*;
    logic [31:0] bool_v;
    logic [31:0] f1_v;
    logic [31:0] f2_v;
    logic [32:0] sum_v;
    logic        inc;
    genvar i;
    // ----------------------------------------
    // per-bit function lookup
    // ----------------------------------------
    // f1 and f2 come out of the same code: f1 is the entry with A=1 xor
    // A=0, f2 the A=0 entry, which is why software xors the codes
    generate
        for (i = 0; i < 32; i++) begin : g_bit
            assign bool_v[i] = p.fcode[{p.c[i], p.b[i], p.a[i]}];
            assign f2_v[i] = p.fcode[{p.c[i], p.b[i], 1'b0}];
            assign f1_v[i] = p.fcode[{p.c[i], p.b[i], 1'b1}] ^ f2_v[i];
        end
    endgenerate
    assign inc = p.add1 | (p.addcin & p.cin);
    always_comb begin
        if (p.arith) begin
            sum_v = {1'b0, p.a & f1_v} + {1'b0, f2_v} + {32'h0, inc};
        end else begin
            sum_v = {1'b0, bool_v} + {32'h0, inc};
        end
    end
    assign p.res  = sum_v[31:0];
    assign p.cout = sum_v[32];
endmodule
`default_nettype wire

// ---- verilog/ppce_top.sv ----
/*
 * condition evaluation, gating and extended alu for one parallel engine.
 * assumes the decoder presents one instruction per valid cycle and
 * the register file supplies operands and the extension register.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppce_cfg.svh"
module ppce_top (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              instr_valid,
    input  wire logic [63:0]       opcode,
    input  wire logic              cond_form,
    input  wire logic              imm32_form,
    input  wire logic              gate_src,
    input  wire logic              gate_res,
    input  wire logic              gate_xfer,
    input  wire logic              ext_op,
    input  wire logic              dst_wr_req,
    input  wire logic              xfer_req,
    input  wire ppce_pkg::ppce_word_t src_a,
    input  wire ppce_pkg::ppce_word_t src_b,
    input  wire ppce_pkg::ppce_word_t src_c,
    input  wire ppce_pkg::ppce_word_t alu_extension_reg,
    input  wire logic              flags_wr,
    input  wire logic [3:0]        flags_in,
    input  wire logic [1:0]        local_relative_sel,
    input  wire logic [1:0]        global_relative_sel,
    input  wire ppce_pkg::ppce_word_t local_addr,
    input  wire ppce_pkg::ppce_word_t global_addr,
    input  wire ppce_pkg::ppce_word_t dram0_base,
    input  wire ppce_pkg::ppce_word_t pram_base,
    output var  ppce_pkg::ppce_word_t result_r,
    output logic                   result_wr_r,
    output logic                   src_use_r,
    output logic                   xfer_go_r,
    output var  ppce_pkg::ppce_word_t local_eff_r,
    output var  ppce_pkg::ppce_word_t global_eff_r,
    output logic                   rel_rsv_r,
    output logic                   cond_true_r,
    output logic [3:0]             flags_r
);
    import ppce_pkg::*;
    ppce_alu_if alu_p ();
    logic [3:0] cond;
    logic       n_f;
    logic       z_f;
    logic       c_f;
    logic       v_f;
    logic       cond_ok;
    logic       g_src;
    logic       g_res;
    logic       g_xfer;
    logic       sgn;
    logic       res_ok;
    logic [3:0] flags_nxt;
    ppce_word_t a_op;
    logic       lower_or_same;
    logic       unsigned_above;
    logic       carry_set_cond;
    logic       carry_clear_cond;
    logic       signed_below;
    logic       signed_at_most;
    logic       signed_at_least;
    logic       signed_above;
    logic       zero_result_cond;
    logic       nonzero_cond;
    logic [1:0] rel_sel [2];
    ppce_word_t rel_adr [2];
    ppce_word_t rel_eff [2];
    logic       rel_bad [2];
    genvar      u;

    // ----------------------------------------
    // condition evaluation
    // ----------------------------------------
    assign cond = opcode[`PPCE_COND_HI:`PPCE_COND_LO];
    assign {n_f, z_f, c_f, v_f} = flags_r;
    // the ordered compares are named once so the signed terms share
    // one xor instead of four copies in the case below
    assign lower_or_same    = ~c_f | z_f;
    assign unsigned_above   = c_f & ~z_f;
    assign carry_set_cond   = c_f;
    assign carry_clear_cond = ~c_f;
    assign signed_below     = n_f ^ v_f;
    assign signed_at_most   = signed_below | z_f;
    assign signed_at_least  = ~signed_below;
    assign signed_above     = signed_at_least & ~z_f;
    assign zero_result_cond = z_f;
    assign nonzero_cond     = ~z_f;
    always_comb begin
        case (cond)
            4'h0: cond_ok = 1'b1;
            4'h1: cond_ok = ~n_f & ~z_f;
            4'h2: cond_ok = lower_or_same;
            4'h3: cond_ok = unsigned_above;
            4'h4: cond_ok = signed_below;
            4'h5: cond_ok = signed_at_most;
            4'h6: cond_ok = signed_at_least;
            4'h7: cond_ok = signed_above;
            4'h8: cond_ok = carry_set_cond;
            4'h9: cond_ok = carry_clear_cond;
            4'hA: cond_ok = zero_result_cond;
            4'hB: cond_ok = nonzero_cond;
            4'hC: cond_ok = v_f;
            4'hD: cond_ok = ~v_f;
            4'hE: cond_ok = n_f;
            4'hF: cond_ok = ~n_f;
            default: cond_ok = 1'b1;
        endcase
    end
    // immediate form: the result is always gated; source and transfer never are
    assign g_src  = cond_form & ~imm32_form & gate_src;
    assign g_xfer = cond_form & ~imm32_form & gate_xfer;
    assign g_res  = imm32_form | (cond_form & gate_res);

    // ----------------------------------------
    // extended alu hookup
    // ----------------------------------------
    // sign steering picks the alternate function code when the chosen
    // input is negative, giving absolute value and signed shifts
    assign sgn = alu_extension_reg[`PPCE_X_SIGNSRC] ? src_c[31] : src_a[31];
    assign a_op = (g_src & ~cond_ok) ? 32'h0 : src_a;
    assign alu_p.a = a_op;
    assign alu_p.b = src_b;
    assign alu_p.c = src_c;
    always_comb begin
        if (ext_op) begin
            if (alu_extension_reg[`PPCE_X_SIGNEN] & sgn) begin
                alu_p.fcode =
                    alu_extension_reg[`PPCE_X_SIGNFC_HI:`PPCE_X_SIGNFC_LO];
            end else begin
                alu_p.fcode = alu_extension_reg[`PPCE_FC_HI:`PPCE_FC_LO];
            end
            alu_p.arith  = alu_extension_reg[`PPCE_X_ARITH];
            alu_p.add1   = alu_extension_reg[`PPCE_X_ADD1];
            alu_p.addcin = alu_extension_reg[`PPCE_X_ADDCIN];
        end else begin
            // plain op falls back to a + b through the same datapath
            alu_p.fcode  = 8'h66;
            alu_p.arith  = 1'b1;
            alu_p.add1   = 1'b0;
            alu_p.addcin = 1'b0;
        end
    end
    assign alu_p.cin = c_f;
    ppce_alu u_alu (
        .p (alu_p)
    );

    // ----------------------------------------
    // result, write and flag update
    // ----------------------------------------
    assign res_ok = ~g_res | cond_ok;
    always_ff @(posedge clk) begin
        if (rst) begin
            result_r    <= 32'h0;
            result_wr_r <= 1'b0;
            src_use_r   <= 1'b0;
            xfer_go_r   <= 1'b0;
            cond_true_r <= 1'b0;
        end else begin
            result_r    <= alu_p.res;
            result_wr_r <= instr_valid & dst_wr_req & res_ok;
            src_use_r   <= instr_valid & ~(g_src & ~cond_ok);
            xfer_go_r   <= instr_valid & xfer_req & ~(g_xfer & ~cond_ok);
            cond_true_r <= cond_ok;
        end
    end
    // a direct load wins over the alu update so software can restore flags
    always_comb begin
        flags_nxt = flags_r;
        if (flags_wr) begin
            flags_nxt = flags_in;
        end else if (instr_valid & dst_wr_req & res_ok) begin
            flags_nxt = {alu_p.res[31], alu_p.res == 32'h0, alu_p.cout,
                         1'b0};
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= `PPCE_FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ----------------------------------------
    // relative addressing
    // ----------------------------------------
    // each unit gets its own copy of one datapath; a reserved code falls back to
    // absolute so a bad opcode still yields a defined address
    assign rel_sel[0] = local_relative_sel;
    assign rel_sel[1] = global_relative_sel;
    assign rel_adr[0] = local_addr;
    assign rel_adr[1] = global_addr;
    generate
        for (u = 0; u < 2; u++) begin : g_unit
            always_comb begin
                case (rel_sel[u])
                    `PPCE_REL_PRAM: begin
                        rel_eff[u] = pram_base + rel_adr[u];
                    end
                    `PPCE_REL_DRAM: begin
                        rel_eff[u] = dram0_base + rel_adr[u];
                    end
                    default: rel_eff[u] = rel_adr[u];
                endcase
            end
            assign rel_bad[u] = rel_sel[u] == 2'h1;
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (rst) begin
            local_eff_r  <= 32'h0;
            global_eff_r <= 32'h0;
            rel_rsv_r    <= 1'b0;
        end else begin
            local_eff_r  <= rel_eff[0];
            global_eff_r <= rel_eff[1];
            rel_rsv_r    <= rel_bad[0] | rel_bad[1];
        end
    end
endmodule
`default_nettype wire

// ---- test/ppce_assertions.sv ----
/* checker for ppce_top: condition, gating, address and flag timing.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module ppce_assertions (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 instr_valid,
    input wire logic [63:0]          opcode,
    input wire logic                 cond_form,
    input wire logic                 imm32_form,
    input wire logic                 gate_res,
    input wire logic                 dst_wr_req,
    input wire logic                 xfer_req,
    input wire logic                 flags_wr,
    input wire logic [3:0]           flags_in,
    input wire logic [1:0]           global_relative_sel,
    input wire ppce_pkg::ppce_word_t global_addr,
    input wire ppce_pkg::ppce_word_t pram_base,
    input wire logic                 result_wr_r,
    input wire logic                 xfer_go_r,
    input wire ppce_pkg::ppce_word_t global_eff_r,
    input wire logic                 cond_true_r,
    input wire logic [3:0]           flags_r
);
    import ppce_pkg::*;
    // ------------------------------
    // properties
    // ------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic ask;
    assign ask = instr_valid && cond_form && !imm32_form;
    chk_cond_always: assert property (ask && opcode[35:32] == 4'h0
        |=> cond_true_r) else $error("code zero not true");
    chk_cond_zero: assert property (ask && opcode[35:32] == 4'hA
        |=> cond_true_r == $past(flags_r[2])) else $error("zero test wrong");
    chk_res_gate: assert property (ask && gate_res && dst_wr_req
        |=> result_wr_r == cond_true_r) else $error("result gate wrong");
    chk_imm_xfer: assert property (instr_valid && imm32_form
        && xfer_req |=> xfer_go_r) else $error("imm form gated transfer");
    chk_pram_addr: assert property (global_relative_sel == 2'h3
        |=> global_eff_r == $past(pram_base) + $past(global_addr))
        else $error("pram relative address wrong");
    chk_flags_hold: assert property (ask && gate_res && !flags_wr
        |=> !cond_true_r |-> $stable(flags_r)) else $error("flags moved");
    chk_flag_load: assert property (flags_wr
        |=> flags_r == $past(flags_in)) else $error("flag load lost");
    chk_reset_clear: assert property (disable iff (1'b0) rst
        |=> !result_wr_r && !xfer_go_r && flags_r == 4'h0)
        else $error("outputs not cleared by reset");
    cover property (ask ##1 !cond_true_r);
    cover property (instr_valid && imm32_form);
    cover property (global_relative_sel == 2'h3);
endmodule
bind ppce_top ppce_assertions u_ppce_assertions (.*);
`default_nettype wire

// ---- test/ppce_regfile_model.sv ----
/* register file model: operands a, b, c and the extension word.
   assumes the bench writes one word per clock before use. */
`timescale 1ns/1ps
`default_nettype none
module ppce_regfile_model (
    input  wire logic            clk,
    input  wire logic            we,
    input  wire logic [1:0]      sel,
    input  wire ppce_pkg::ppce_word_t wd,
    output var  ppce_pkg::ppce_word_t q [4]
);
    import ppce_pkg::*;
    // ------------------------------
    // storage
    // ------------------------------
    always_ff @(posedge clk) begin
        if (we) begin
            q[sel] <= wd;
        end
    end
endmodule
`default_nettype wire

// ---- test/ppce_top_tb.sv ----
/* self-checking bench for ppce_top.
   assumes the register file model feeds operands and extension word. */
`timescale 1ns/1ps
`default_nettype none
module ppce_top_tb;
    import ppce_pkg::*;
    // ------------------------------
    // signals and tables
    // ------------------------------
    logic clk = 0, rst = 1, v = 0, cf = 0, imf = 0, eo = 0, gs = 0;
    logic gr = 0, gx = 0, dw = 0, xr = 0, fw = 0, we = 0;
    logic rwr, su, xg, rsv, ct;
    logic [63:0] op = 0;
    logic [3:0]  fi = 0, fl;
    logic [1:0]  lsel = 0, gsel = 0, sel = 0;
    ppce_word_t  wd = 0, res, leff, geff, rf [4];
    ppce_word_t  la = 32'h00000104, ga = 32'h00000208;
    ppce_word_t  db = 32'h00001000, pb = 32'h00002000;
    int          miscompares = 0, samples_checked = 0;
    logic [7:0]  andt [16] = '{8'h00, 8'hAA, 8'h88, 8'h22, 8'hA0, 8'h0A,
        8'h80, 8'h2A, 8'hA8, 8'h02, 8'h08, 8'hA2, 8'h8A, 8'h20, 8'h28,
        8'h82};
    logic [7:0]  addt [16] = '{8'h00, 8'hFF, 8'hCC, 8'h33, 8'hF0, 8'h0F,
        8'hC0, 8'h3F, 8'hFC, 8'h03, 8'h0C, 8'hF3, 8'hCF, 8'h30, 8'h3C,
        8'hC3};
    ppce_regfile_model u_ppce_regfile_model (.clk(clk), .we(we),
        .sel(sel), .wd(wd), .q(rf));
    ppce_top u_ppce_top (.clk(clk), .rst(rst), .instr_valid(v),
        .opcode(op), .cond_form(cf), .imm32_form(imf), .gate_src(gs),
        .gate_res(gr), .gate_xfer(gx), .ext_op(eo), .dst_wr_req(dw),
        .xfer_req(xr), .src_a(rf[0]), .src_b(rf[1]), .src_c(rf[2]),
        .alu_extension_reg(rf[3]), .flags_wr(fw), .flags_in(fi),
        .local_relative_sel(lsel), .global_relative_sel(gsel),
        .local_addr(la), .global_addr(ga), .dram0_base(db),
        .pram_base(pb), .result_r(res), .result_wr_r(rwr),
        .src_use_r(su), .xfer_go_r(xg), .local_eff_r(leff),
        .global_eff_r(geff), .rel_rsv_r(rsv), .cond_true_r(ct),
        .flags_r(fl));
    initial begin
        forever #25 clk = ~clk;
    end
    // a hang counts as a mismatch and ends the run here
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        tally_and_finish;
    end
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic load(input ppce_word_t w0, w1, w2, w3);
        ppce_word_t w [4];
        w = '{w0, w1, w2, w3};
        we = 1;
        for (int i = 0; i < 4; i++) begin
            sel = i[1:0];
            wd = w[i];
            tick;
        end
        we = 0;
    endtask
    // flags are {n, z, c, v}
    function automatic logic cref(input logic [3:0] k, input logic [3:0] f);
        logic [15:0] t;
        t = {!f[3], f[3], !f[0], f[0], !f[2], f[2], !f[1], f[1],
            !(f[3] ^ f[0]) & !f[2], !(f[3] ^ f[0]), (f[3] ^ f[0]) | f[2],
            f[3] ^ f[0], f[1] & !f[2], !f[1] | f[2], !f[3] & !f[2], 1'b1};
        return t[k];
    endfunction
    function automatic ppce_word_t bref(input logic [7:0] fc,
                                        input ppce_word_t a, b, c);
        for (int j = 0; j < 32; j++) bref[j] = fc[{c[j], b[j], a[j]}];
    endfunction
    // ------------------------------
    // test sequence
    // ------------------------------
    initial begin
        logic [3:0] k, f;
        logic [1:0] m;
        logic       cv;
        logic [7:0] fc;
        ppce_word_t a, e;
        repeat (2) tick;
        rst = 0;
        fw = 1;
        dw = 1;
        for (int i = 0; i < 512; i++) begin
            {imf, f, k} = i[8:0];
            fi = f;
            v = 0;
            tick;
            {v, cf, gs} = {1'b1, !imf, i[4] ^ i[0]};
            {gr, gx} = {!i[5], i[6] ^ i[1]};
            xr = !i[2];
            op[35:32] = k;
            tick;
            cv = cref(k, f);
            chk(ct, cv);
            chk(rwr, cv | !(imf | gr));
            chk(su, imf | cv | !gs);
            chk(xg, xr & (imf | cv | !gx));
        end
        fi = 4'h0;
        tick;
        {fw, cf, gr, imf} = 4'b0110;
        op[35:32] = 4'hA;
        tick;
        chk(rwr, 0);
        v = 0;
        tick;
        chk(fl, 4'h0);
        for (int s = 0; s < 4; s++) begin
            {lsel, gsel} = {s[1:0], ~s[1:0]};
            tick;
            e = s == 3 ? pb : s == 2 ? db : 32'h0;
            if (s != 1) chk(leff, e + la);
            e = s == 0 ? pb : s == 1 ? db : 32'h0;
            if (s != 2) chk(geff, e + ga);
            chk(rsv, s == 1 || s == 2);
        end
        // ungated from here on, so every alu result is written
        fw = 1;
        cf = 0;
        for (int j = 0; j < 64; j++) begin
            a = j[5] ? 32'h8F0F33C5 : 32'h0F0F33C5;
            m = 2'(j % 3);
            fi = {2'b00, j[0], 1'b0};
            fc = andt[j % 16] ^ addt[(j + 5) % 16];
            e = j[4] ? bref(andt[j % 16], a, 32'h5A5AA5A5, 32'hFF00F0F0)
                + bref(addt[(j + 5) % 16], a, 32'h5A5AA5A5, 32'hFF00F0F0)
                : bref(fc, a, 32'h5A5AA5A5, 32'hFF00F0F0);
            e = e + ((m == 1) | (m == 2 & j[0]));
            // sign of a picks the alternate code, so main and alternate swap
            load(a, 32'h5A5AA5A5, 32'hFF00F0F0, {2'b01, m == 2, m == 1, j[4],
                j[5] ? ~fc : fc, 11'h000, j[5] ? fc : ~fc});
            {v, eo} = 2'b11;
            tick;
            v = 0;
            chk(res, e);
            chk(rwr, 1);
        end
        // plain op is a + b; flags take N, Z and carry, V reads back 0
        fw = 0;
        for (int p = 0; p < 2; p++) begin
            a = p ? 32'hFFFFFFFF : 32'hC0000000;
            load(a, p ? 32'h00000001 : a, 32'h0, 32'h0);
            {v, eo} = 2'b10;
            tick;
            v = 0;
            chk(res, p ? 32'h0 : 32'h80000000);
            chk(fl, p ? 4'h6 : 4'hA);
        end
        rst = 1;
        tick;
        chk(res, 0);
        chk({rwr, xg, ct, su, rsv, fl}, 0);
        chk(leff, 0);
        chk(geff, 0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
